// ==== inc/cdi_pkg.sv ====
package cdi_pkg;
  // clock and timing
  localparam int CLK_NS = 8;
  localparam int EXEC_NS = 18500;
  localparam int HOME_NS = 760000;
  localparam int BLINK_NS = 185000000;
  localparam int EXEC_CYC = (EXEC_NS + CLK_NS - 1) / CLK_NS;
  localparam int HOME_CYC = (HOME_NS + CLK_NS - 1) / CLK_NS;
  localparam int BLINK_CYC = BLINK_NS / CLK_NS;
  // apb register offsets
  localparam logic [7:0] A_INSTR = 8'h00;
  localparam logic [7:0] A_DATA = 8'h04;
  localparam logic [7:0] A_STATE = 8'h08;
  localparam logic [7:0] A_CTRL = 8'h0c;
  // display ram layout
  localparam logic [7:0] SPACE_CODE = 8'h20;
  localparam logic [6:0] LINE1_END = 7'h27;
  localparam logic [6:0] LINE2_BASE = 7'h40;
  localparam logic [6:0] LINE2_END = 7'h67;
  localparam logic [6:0] ONE_END = 7'h4f;
  localparam logic [5:0] OFF_LAST = 6'h27;
  localparam logic [6:0] CLR_LAST = 7'h7f;
  // duty codes and link enable reset value
  localparam logic [1:0] DUTY_8 = 2'h0;
  localparam logic [1:0] DUTY_11 = 2'h1;
  localparam logic [1:0] DUTY_16 = 2'h2;
  localparam logic LINK_EN_RST = 1'b1;

  typedef enum logic {S_IDLE = 1'b0, S_BUSY = 1'b1} cdi_state_e;

  typedef enum logic [3:0] {
    K_NONE = 4'h0, K_CLEAR = 4'h1, K_HOME = 4'h2, K_ENTRY = 4'h3, K_DISP = 4'h4,
    K_SHIFT = 4'h5, K_FUNC = 4'h6, K_CGA = 4'h7, K_DDA = 4'h8
  } cdi_kind_e;

  typedef struct packed {
    logic rs;
    logic rd;
    logic [7:0] data;
  } cdi_op_s;

  typedef struct packed {
    logic display_on;
    logic cursor_on;
    logic blink_on;
    logic step_up;
    logic entry_shift;
    logic wide_bus;
    logic two_line;
    logic font_tall;
  } cdi_mode_s;

  localparam cdi_mode_s MODE_RST = 8'h1c;

  typedef struct packed {
    logic on;
    logic cursor_show;
    logic blink_solid;
    logic [1:0] duty;
    logic [5:0] offset;
    logic [6:0] cursor_addr;
  } cdi_panel_s;

  // the kind is fixed by the highest set bit; lower bits are operands or ignored
  function automatic cdi_kind_e cdi_decode(input logic [7:0] d);
    casez (d)
      8'b1???????: return K_DDA;
      8'b01??????: return K_CGA;
      8'b001?????: return K_FUNC;
      8'b0001????: return K_SHIFT;
      8'b00001???: return K_DISP;
      8'b000001??: return K_ENTRY;
      8'b0000001?: return K_HOME;
      8'b00000001: return K_CLEAR;
      default: return K_NONE;
    endcase
  endfunction : cdi_decode

  function automatic logic [6:0] cdi_step(input logic [6:0] a, input logic up, input logic cg, input logic two);
    if (cg) return {1'b0, up ? a[5:0] + 6'h1 : a[5:0] - 6'h1};
    if (two) begin
      if (up) return (a == LINE1_END) ? LINE2_BASE : (a == LINE2_END) ? 7'h00 : a + 7'h1;
      return (a == LINE2_BASE) ? LINE1_END : (a == 7'h00) ? LINE2_END : a - 7'h1;
    end
    if (up) return (a == ONE_END) ? 7'h00 : a + 7'h1;
    return (a == 7'h00) ? ONE_END : a - 7'h1;
  endfunction : cdi_step

  // window start; a left shift moves the window forward by one column
  function automatic logic [5:0] cdi_roll(input logic [5:0] o, input logic left);
    if (left) return (o == OFF_LAST) ? 6'h00 : o + 6'h1;
    return (o == 6'h00) ? OFF_LAST : o - 6'h1;
  endfunction : cdi_roll

  function automatic logic [31:0] cdi_nib(input logic [7:0] b, input logic wide, input logic ph);
    if (wide) return {24'h0, b};
    return ph ? {24'h0, b[3:0], 4'h0} : {24'h0, b[7:4], 4'h0};
  endfunction : cdi_nib
endpackage : cdi_pkg

// ==== verilog/cdi_top.sv ====
`timescale 1ns/10ps
module cdi_top #(
  parameter int HOME_CYCLES = cdi_pkg::HOME_CYC,
  parameter int BLINK_CYCLES = cdi_pkg::BLINK_CYC
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic chip_select_n,
  input wire logic serial_clock,
  input wire logic serial_data_in,
  input wire logic instr_data_select,
  input wire logic [6:0] scan_addr,
  output logic [7:0] scan_data,
  output cdi_pkg::cdi_panel_s panel,
  output logic busy_indicator
);
  import cdi_pkg::*;

  logic cs_s1, cs_s2, ck_s1, ck_s2, ck_s3, di_s1, di_s2, rs_s1, rs_s2;
  logic [2:0] bit_cnt;
  logic [7:0] ser_sr;
  logic ser_valid;
  cdi_op_s ser_op;
  logic link_en;
  logic nib_phase;
  logic [3:0] nib_hi;
  cdi_mode_s mode;
  logic [6:0] address_counter_reg;
  logic sel_cg;
  logic [5:0] offset;
  logic pre_pend;
  logic [7:0] out_data;
  cdi_state_e state;
  logic [31:0] cnt;
  logic clearing;
  logic [6:0] clr_idx;
  logic [31:0] blink_cnt;
  logic blink_phase;
  logic [7:0] display_data_ram [128];
  logic [7:0] glyph_pattern_ram [64];

  // pins come from outside; two flops before any use
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cs_s1 <= 1'b1;
      cs_s2 <= 1'b1;
      ck_s1 <= 1'b0;
      ck_s2 <= 1'b0;
      ck_s3 <= 1'b0;
      di_s1 <= 1'b0;
      di_s2 <= 1'b0;
      rs_s1 <= 1'b0;
      rs_s2 <= 1'b0;
    end else begin
      cs_s1 <= chip_select_n;
      cs_s2 <= cs_s1;
      ck_s1 <= serial_clock;
      ck_s2 <= ck_s1;
      ck_s3 <= ck_s2;
      di_s1 <= serial_data_in;
      di_s2 <= di_s1;
      rs_s1 <= instr_data_select;
      rs_s2 <= rs_s1;
    end
  end

  // serial link is write only, msb first, eight bits per byte
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      bit_cnt <= 3'h0;
      ser_sr <= 8'h00;
      ser_valid <= 1'b0;
      ser_op <= '0;
    end else begin
      ser_valid <= 1'b0;
      if (cs_s2) begin
        bit_cnt <= 3'h0;
      end else if (ck_s2 && !ck_s3) begin
        ser_sr <= {ser_sr[6:0], di_s2};
        bit_cnt <= bit_cnt + 3'h1;
        if (bit_cnt == 3'h7) begin
          ser_valid <= 1'b1;
          ser_op <= '{rs: rs_s2, rd: 1'b0, data: {ser_sr[6:0], di_s2}};
        end
      end
    end
  end

  logic acc, port_hit, known, byte_done, apb_op_valid, go_req, op_go, long_op;
  cdi_op_s apb_op, go_op;
  cdi_kind_e kind;
  logic is_wr, is_rd, is_instr;
  logic [6:0] step_ac;

  assign acc = psel && penable;
  assign port_hit = (paddr == A_INSTR) || (paddr == A_DATA);
  assign known = port_hit || (paddr == A_STATE) || (paddr == A_CTRL);
  assign pready = 1'b1;
  assign pslverr = acc && !known;
  assign byte_done = mode.wide_bus || nib_phase;
  // a status read is answered at once and never counts as an operation
  assign apb_op_valid = acc && port_hit && byte_done && !((paddr == A_INSTR) && !pwrite);
  assign apb_op.rs = (paddr == A_DATA);
  assign apb_op.rd = !pwrite;
  assign apb_op.data = mode.wide_bus ? pwdata[7:0] : {nib_hi, pwdata[7:4]};
  // apb wins a same-cycle clash; the serial byte is then dropped
  assign go_op = apb_op_valid ? apb_op : ser_op;
  assign go_req = apb_op_valid || (ser_valid && link_en);
  assign op_go = go_req && (state == S_IDLE);
  assign kind = go_op.rs ? K_NONE : cdi_decode(go_op.data);
  assign is_wr = go_op.rs && !go_op.rd;
  assign is_rd = go_op.rs && go_op.rd;
  assign is_instr = !go_op.rs && !go_op.rd;
  assign long_op = is_instr && ((kind == K_CLEAR) || (kind == K_HOME));
  assign step_ac = cdi_step(address_counter_reg, mode.step_up, sel_cg, mode.two_line);

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      link_en <= LINK_EN_RST;
    end else if (acc && pwrite && (paddr == A_CTRL)) begin
      link_en <= pwdata[0];
    end
  end

  // nibble bookkeeping: high nibble first on both writes and reads
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      nib_phase <= 1'b0;
      nib_hi <= 4'h0;
    end else if (mode.wide_bus) begin
      nib_phase <= 1'b0;
    end else if (acc && port_hit) begin
      nib_phase <= !nib_phase;
      if (pwrite && !nib_phase) begin
        nib_hi <= pwdata[7:4];
      end
    end
  end

  // modes, address counter and display window
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      mode <= MODE_RST;
      address_counter_reg <= 7'h00;
      sel_cg <= 1'b0;
      offset <= 6'h00;
      pre_pend <= 1'b0;
    end else begin
      pre_pend <= 1'b0;
      if (op_go && go_op.rs) begin
        address_counter_reg <= step_ac;
        pre_pend <= 1'b1;
        if (is_wr && !sel_cg && mode.entry_shift) begin
          offset <= cdi_roll(offset, mode.step_up);
        end
      end else if (op_go && is_instr) begin
        unique case (kind)
          K_CLEAR: begin
            address_counter_reg <= 7'h00;
            sel_cg <= 1'b0;
            offset <= 6'h00;
            mode.step_up <= 1'b1;
          end
          K_HOME: begin
            address_counter_reg <= 7'h00;
            sel_cg <= 1'b0;
            offset <= 6'h00;
          end
          K_ENTRY: begin
            mode.step_up <= go_op.data[1];
            mode.entry_shift <= go_op.data[0];
          end
          K_DISP: begin
            mode.display_on <= go_op.data[2];
            mode.cursor_on <= go_op.data[1];
            mode.blink_on <= go_op.data[0];
          end
          K_SHIFT: begin
            if (go_op.data[3]) begin
              offset <= cdi_roll(offset, !go_op.data[2]);
            end else begin
              address_counter_reg <= cdi_step(address_counter_reg, go_op.data[2], sel_cg, mode.two_line);
              pre_pend <= 1'b1;
            end
          end
          K_FUNC: begin
            mode.wide_bus <= go_op.data[4];
            mode.two_line <= go_op.data[3];
            mode.font_tall <= go_op.data[2];
          end
          K_CGA: begin
            address_counter_reg <= {1'b0, go_op.data[5:0]};
            sel_cg <= 1'b1;
            pre_pend <= 1'b1;
          end
          K_DDA: begin
            address_counter_reg <= go_op.data[6:0];
            sel_cg <= 1'b0;
            pre_pend <= 1'b1;
          end
          K_NONE: begin
          end
        endcase
      end
    end
  end

  // busy timer
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state <= S_IDLE;
      cnt <= 32'h0;
    end else begin
      unique case (state)
        S_IDLE: begin
          if (op_go) begin
            state <= S_BUSY;
            cnt <= long_op ? HOME_CYCLES - 1 : EXEC_CYC - 1;
          end
        end
        S_BUSY: begin
          if (cnt == 32'h0) begin
            state <= S_IDLE;
          end else begin
            cnt <= cnt - 32'h1;
          end
        end
      endcase
    end
  end
  assign busy_indicator = (state == S_BUSY);

  // clear fills one location per cycle; it ends well inside the busy time
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      clearing <= 1'b0;
      clr_idx <= 7'h00;
    end else if (op_go && is_instr && (kind == K_CLEAR)) begin
      clearing <= 1'b1;
      clr_idx <= 7'h00;
    end else if (clearing) begin
      clr_idx <= clr_idx + 7'h1;
      if (clr_idx == CLR_LAST) begin
        clearing <= 1'b0;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (clearing) begin
      display_data_ram[clr_idx] <= SPACE_CODE;
    end else if (op_go && is_wr && !sel_cg) begin
      display_data_ram[address_counter_reg] <= go_op.data;
    end
    if (op_go && is_wr && sel_cg) begin
      glyph_pattern_ram[address_counter_reg[5:0]] <= go_op.data;
    end
  end

  // read register holds the byte the next data read returns
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      out_data <= 8'h00;
      scan_data <= 8'h00;
    end else begin
      scan_data <= display_data_ram[scan_addr];
      if (pre_pend) begin
        out_data <= sel_cg ? glyph_pattern_ram[address_counter_reg[5:0]] : display_data_ram[address_counter_reg];
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      blink_cnt <= 32'h0;
      blink_phase <= 1'b0;
    end else if (!mode.blink_on) begin
      blink_cnt <= 32'h0;
      blink_phase <= 1'b0;
    end else if (blink_cnt == BLINK_CYCLES - 1) begin
      blink_cnt <= 32'h0;
      blink_phase <= !blink_phase;
    end else begin
      blink_cnt <= blink_cnt + 32'h1;
    end
  end

  assign panel.on = mode.display_on;
  assign panel.cursor_show = mode.display_on && mode.cursor_on;
  assign panel.blink_solid = mode.display_on && mode.blink_on && blink_phase;
  assign panel.duty = mode.two_line ? DUTY_16 : (mode.font_tall ? DUTY_11 : DUTY_8);
  assign panel.offset = offset;
  assign panel.cursor_addr = address_counter_reg;

  always_comb begin
    unique case (paddr)
      A_INSTR: prdata = cdi_nib({busy_indicator, address_counter_reg}, mode.wide_bus, nib_phase);
      A_DATA: prdata = cdi_nib(out_data, mode.wide_bus, nib_phase);
      A_STATE: prdata = {14'h0, panel.duty, blink_phase, sel_cg, offset, mode};
      A_CTRL: prdata = {31'h0, link_en};
      default: prdata = 32'h0;
    endcase
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  busy_rise_a: assert property (op_go |=> busy_indicator)
    else $error("busy not raised on accepted byte");
  exec_time_a: assert property (op_go && !long_op |=> cnt == EXEC_CYC - 1)
    else $error("short execution time wrong");
  home_time_a: assert property (op_go && long_op |=> cnt == HOME_CYCLES - 1)
    else $error("long execution time wrong");
  write_step_a: assert property (op_go && is_wr |=> address_counter_reg == $past(step_ac))
    else $error("counter did not step after write");
  line_wrap_a: assert property (op_go && is_wr && mode.two_line && mode.step_up && !sel_cg
    && address_counter_reg == LINE1_END |=> address_counter_reg == LINE2_BASE)
    else $error("no wrap to line two");
  dshift_ac_a: assert property (op_go && kind == K_SHIFT && go_op.data[3] |=> $stable(address_counter_reg))
    else $error("display shift moved counter");
  entry_shift_a: assert property (op_go && is_wr && !sel_cg && mode.entry_shift && mode.step_up
    && offset == 6'h00 |=> offset == 6'h01)
    else $error("entry shift did not move window left");
  blank_panel_a: assert property (!mode.display_on |-> !panel.on && !panel.cursor_show && !panel.blink_solid)
    else $error("panel not blanked");
  duty_sel_a: assert property (mode.two_line |-> panel.duty == DUTY_16)
    else $error("two-line duty wrong");
  status_read_a: assert property (psel && !pwrite && paddr == A_INSTR && mode.wide_bus
    |-> prdata[7] == busy_indicator && prdata[6:0] == address_counter_reg)
    else $error("status byte wrong");
  preload_a: assert property (op_go && kind == K_DDA |=> pre_pend ##1 busy_indicator [*2])
    else $error("address set did not preload");

  clear_c: cover property (op_go && kind == K_CLEAR ##1 clearing [*8]);
  read_c: cover property (op_go && is_rd);
  serial_c: cover property (ser_valid && link_en && op_go);
  nibble_c: cover property (acc && port_hit && !mode.wide_bus && nib_phase);
endmodule : cdi_top

// ==== bench/cdi_host_model.sv ====
`timescale 1ns/10ps
module cdi_host_model (
  input wire logic clock,
  output logic chip_select_n,
  output logic serial_clock,
  output logic serial_data_in,
  output logic instr_data_select
);
  import cdi_pkg::*;
  initial begin
    chip_select_n = 1'b1;
    serial_clock = 1'b0;
    serial_data_in = 1'b0;
    instr_data_select = 1'b0;
  end
  // write only: the serial link has no read path
  // frames carry all eight bits whatever the bus width bit
  task automatic send(input logic rs, input logic [7:0] b);
    int i;
    chip_select_n <= 1'b0;
    instr_data_select <= rs;
    for (i = 7; i >= 0; i--) begin
      serial_data_in <= b[i];
      repeat (10) @(posedge clock);
      serial_clock <= 1'b1;
      repeat (10) @(posedge clock);
      serial_clock <= 1'b0;
    end
    repeat (10) @(posedge clock);
    chip_select_n <= 1'b1;
    // released lines show the inverse so a stale value never looks valid
    serial_data_in <= ~b[0];
    instr_data_select <= ~rs;
    @(posedge clock);
  endtask : send
endmodule : cdi_host_model

// ==== bench/tb.sv ====
`timescale 1ns/10ps
module tb;
  import cdi_pkg::*;
  logic clock, rst_n, psel, penable, pwrite, pready, pslverr, busy_indicator, er, bl;
  logic chip_select_n, serial_clock, serial_data_in, instr_data_select;
  logic [7:0] paddr, scan_data;
  logic [31:0] pwdata, prdata, v;
  logic [6:0] scan_addr;
  cdi_panel_s panel;
  int err_count, compares, run, last_run, tg;
  logic [1:0] dt [3] = '{DUTY_8, DUTY_11, DUTY_16};
  logic [7:0] sc [4] = '{8'h10, 8'h14, 8'h18, 8'h1c};
  logic [6:0] sa [4] = '{7'h01, 7'h02, 7'h02, 7'h02};
  // the reset entry mode shifts the window on the first display write, so the shifts start from 1
  logic [5:0] so [4] = '{6'h01, 6'h01, 6'h02, 6'h01};

  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end

  cdi_top #(.HOME_CYCLES(200), .BLINK_CYCLES(16)) i_cdi_top (.clock(clock), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .chip_select_n(chip_select_n), .serial_clock(serial_clock),
    .serial_data_in(serial_data_in), .instr_data_select(instr_data_select), .scan_addr(scan_addr),
    .scan_data(scan_data), .panel(panel), .busy_indicator(busy_indicator));
  cdi_host_model i_cdi_host_model (.clock(clock), .chip_select_n(chip_select_n), .serial_clock(serial_clock),
    .serial_data_in(serial_data_in), .instr_data_select(instr_data_select));

  // length of the last busy run, in clock cycles
  always @(posedge clock) begin
    if (busy_indicator === 1'b1) run <= run + 1;
    else if (run != 0) begin
      last_run <= run;
      run <= 0;
    end
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rdat,
                     output logic err);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clock);
    penable <= 1'b1;
    // answer and read data are taken at the edge that samples pready high; a hang is left to the watchdog
    do begin
      @(posedge clock);
    end while (pready !== 1'b1);
    rdat = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
  endtask : apb

  task automatic wait_idle();
    do begin
      @(negedge clock);
    end while (busy_indicator !== 1'b0);
    repeat (2) @(posedge clock);
  endtask : wait_idle

  task automatic op(input logic [7:0] a, input logic [7:0] b);
    apb(1'b1, a, {24'h0, b}, v, er);
    wait_idle();
  endtask : op

  task automatic rd_reg(input logic [7:0] a);
    apb(1'b0, a, 32'h0, v, er);
  endtask : rd_reg

  task automatic scan_chk(input logic [6:0] a, input logic [7:0] e);
    scan_addr <= a;
    repeat (2) @(posedge clock);
    @(negedge clock);
    check("scan_data", scan_data, e);
    @(posedge clock);
  endtask : scan_chk

  task automatic done_test(input string name);
    $display("test %s done", name);
  endtask : done_test

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : complete_run

  initial begin
    #760000;
    err_count++;
    complete_run();
  end

  initial begin
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    scan_addr = 7'h00;
    repeat (16) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    rd_reg(A_INSTR);
    check("status", v, 32'h0);
    rd_reg(A_CTRL);
    check("link enable", v[0], 1'b1);
    rd_reg(A_STATE);
    check("step and width", {v[4], v[2]}, 2'b11);
    check("entry shift after reset", v[3], 1'b1);
    check("panel on", panel.on, 1'b0);
    apb(1'b0, 8'h10, 32'h0, v, er);
    check("pslverr", er, 1'b1);
    check("unmapped data", v, 32'h0);
    done_test("reset");
    for (int i = 0; i < 3; i++) begin
      op(A_INSTR, 8'h30 + 8'(i * 4));
      check("duty", panel.duty, dt[i]);
    end
    check("exec cycles", last_run inside {[EXEC_CYC - 1:EXEC_CYC + 1]}, 1'b1);
    op(A_INSTR, 8'h01);
    check("home cycles", last_run inside {[199:201]}, 1'b1);
    done_test("function");
    op(A_INSTR, 8'ha7);
    rd_reg(A_INSTR);
    check("status counter", v, 32'h27);
    apb(1'b1, A_DATA, 32'h41, v, er);
    rd_reg(A_INSTR);
    check("busy bit", v[7], 1'b1);
    wait_idle();
    check("line wrap", panel.cursor_addr, 7'h40);
    scan_chk(7'h27, 8'h41);
    op(A_INSTR, 8'h04);
    op(A_DATA, 8'h42);
    check("step down", panel.cursor_addr, 7'h27);
    scan_chk(7'h40, 8'h42);
    op(A_INSTR, 8'h06);
    // second address set lands while busy and must be dropped
    apb(1'b1, A_INSTR, 32'h81, v, er);
    apb(1'b1, A_INSTR, 32'h85, v, er);
    wait_idle();
    check("dropped while busy", panel.cursor_addr, 7'h01);
    done_test("address");
    op(A_INSTR, 8'h80);
    op(A_DATA, 8'h55);
    rd_reg(A_DATA);
    wait_idle();
    check("read after write", v[7:0], 8'h20);
    check("counter after read", panel.cursor_addr, 7'h02);
    scan_chk(7'h00, 8'h55);
    done_test("readback");
    for (int i = 0; i < 4; i++) begin
      op(A_INSTR, sc[i]);
      check("shift counter", panel.cursor_addr, sa[i]);
      check("shift offset", panel.offset, so[i]);
    end
    op(A_INSTR, 8'h07);
    op(A_DATA, 8'h33);
    check("counter", panel.cursor_addr, 7'h03);
    check("entry shift left", panel.offset, 6'h02);
    op(A_INSTR, 8'h05);
    op(A_DATA, 8'h34);
    check("entry shift right", panel.offset, 6'h01);
    op(A_INSTR, 8'h06);
    done_test("shift");
    op(A_INSTR, 8'h0f);
    check("display on", panel.on, 1'b1);
    rd_reg(A_STATE);
    check("display bits", v[7:5], 3'b111);
    bl = panel.blink_solid;
    tg = 0;
    repeat (64) begin
      @(negedge clock);
      if (panel.blink_solid !== bl) tg++;
      bl = panel.blink_solid;
    end
    @(posedge clock);
    check("blink toggles", tg inside {[3:4]}, 1'b1);
    op(A_INSTR, 8'h08);
    check("display off", panel.on, 1'b0);
    check("cursor hidden", panel.cursor_show, 1'b0);
    rd_reg(A_STATE);
    check("step kept", v[4], 1'b1);
    scan_chk(7'h00, 8'h55);
    done_test("display");
    op(A_INSTR, 8'h02);
    check("home cycles", last_run inside {[199:201]}, 1'b1);
    check("home counter", panel.cursor_addr, 7'h00);
    check("home offset", panel.offset, 6'h00);
    done_test("home");
    op(A_INSTR, 8'h45);
    rd_reg(A_STATE);
    check("glyph select", v[14], 1'b1);
    check("glyph counter", panel.cursor_addr, 7'h05);
    op(A_DATA, 8'haa);
    check("glyph step", panel.cursor_addr, 7'h06);
    op(A_INSTR, 8'h45);
    rd_reg(A_DATA);
    wait_idle();
    check("glyph read", v[7:0], 8'haa);
    done_test("glyph");
    op(A_INSTR, 8'h28);
    apb(1'b1, A_INSTR, 32'h80, v, er);
    apb(1'b1, A_INSTR, 32'ha0, v, er);
    wait_idle();
    check("nibble counter", panel.cursor_addr, 7'h0a);
    apb(1'b1, A_INSTR, 32'h30, v, er);
    apb(1'b1, A_INSTR, 32'h80, v, er);
    wait_idle();
    rd_reg(A_STATE);
    check("wide bus", v[2], 1'b1);
    done_test("nibble");
    i_cdi_host_model.send(1'b0, 8'h90);
    wait_idle();
    check("serial address", panel.cursor_addr, 7'h10);
    i_cdi_host_model.send(1'b1, 8'h5a);
    wait_idle();
    check("serial step", panel.cursor_addr, 7'h11);
    scan_chk(7'h10, 8'h5a);
    apb(1'b1, A_CTRL, 32'h0, v, er);
    i_cdi_host_model.send(1'b0, 8'h80);
    check("link off busy", busy_indicator, 1'b0);
    check("link off counter", panel.cursor_addr, 7'h11);
    done_test("serial");
    complete_run();
  end
endmodule : tb
